// file: core/fee_pkg.sv
// fee_pkg: constants and carriers of the flash eeprom emulation core
// assumes a half-word flash with two equal erase sectors, same clock
package fee_pkg;

   localparam int unsigned AW         = 14;
   localparam int unsigned PAGE_BYTES = 16384;
   localparam int unsigned PAGE_HW    = PAGE_BYTES / 2;

   // half-word offsets inside a page
   localparam logic [AW-1:0] HDR_OFF     = 14'h0000;
   localparam logic [AW-1:0] FIRST_ENTRY = 14'h0002;
   localparam logic [AW-1:0] ENTRY_HW    = 14'h0002;
   localparam logic [AW-1:0] PAGE_END    = AW'(PAGE_HW);

   // page header codes, erased flash reads all ones
   localparam logic [15:0] HDR_ERASED  = 16'hffff;
   localparam logic [15:0] HDR_RECEIVE = 16'heeee;
   localparam logic [15:0] HDR_VALID   = 16'h0000;

   // example variable table
   localparam int unsigned NVAR      = 3;
   localparam logic [47:0] VAR_TABLE = 48'h7777_6666_5555;

   typedef enum logic [1:0] {
      FEE_RD    = 2'b00,
      FEE_PROG  = 2'b01,
      FEE_ERASE = 2'b10
   } fee_op_t;

   typedef enum logic [1:0] {
      P_USE = 2'b00,
      P_MKV = 2'b01,
      P_TX  = 2'b10
   } fee_plan_t;

   // erase picks the sector from addr msb
   typedef struct packed {
      logic          rd;
      logic          prog;
      logic          erase;
      logic [AW-1:0] addr;
      logic [15:0]   data;
   } fee_fcmd_t;

   typedef struct packed {
      logic        write;
      logic [15:0] vaddr;
      logic [15:0] wdata;
   } fee_req_t;

   typedef struct packed {
      logic [15:0] data;
      logic        lookup_result_flag;
      logic        page_full;
   } fee_resp_t;

endpackage

// file: core/fee_fop.sv
// fee_fop: one flash operation at a time, read, program or erase
// assumes the caller holds op, addr and wdata until done
`timescale 1ns/10ps
module fee_fop (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              start,
   input  wire fee_pkg::fee_op_t  op,
   input  wire logic [13:0]       addr,
   input  wire logic [15:0]       wdata,
   output logic                   done,
   output logic [15:0]            rdata,
   output fee_pkg::fee_fcmd_t     cmd,
   input  wire logic              fl_busy,
   input  wire logic              fl_rvalid,
   input  wire logic [15:0]       fl_rdata
);

   typedef enum logic [1:0] {
      F_IDLE   = 2'b00,
      F_POLL   = 2'b01,
      F_SETTLE = 2'b10,
      F_WAIT   = 2'b11
   } fee_fst_t;

   fee_fst_t           fst;
   fee_fst_t           next_fst;
   fee_pkg::fee_fcmd_t next_cmd;
   logic               next_done;
   logic [15:0]        next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // an erase or program left running across reset is waited out in poll
   always_comb begin
      next_fst   = fst;
      next_cmd   = '0;
      next_done  = 1'b0;
      next_rdata = rdata;
      case (fst)
         F_IDLE: begin
            if (start) next_fst = F_POLL;
         end
         F_POLL: begin
            if (!fl_busy) begin
               next_cmd.rd    = (op == fee_pkg::FEE_RD);
               next_cmd.prog  = (op == fee_pkg::FEE_PROG);
               next_cmd.erase = (op == fee_pkg::FEE_ERASE);
               next_cmd.addr  = addr;
               next_cmd.data  = wdata;
               next_fst = (op == fee_pkg::FEE_RD) ? F_WAIT : F_SETTLE;
            end
         end
         // one spare cycle so busy is seen high
         F_SETTLE: next_fst = F_WAIT;
         F_WAIT: begin
            if (op == fee_pkg::FEE_RD) begin
               if (fl_rvalid) begin
                  next_rdata = fl_rdata;
                  next_done  = 1'b1;
                  next_fst   = F_IDLE;
               end
            end else if (!fl_busy) begin
               next_done = 1'b1;
               next_fst  = F_IDLE;
            end
         end
         default: next_fst = F_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fst   <= F_IDLE;
         cmd   <= '0;
         done  <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         fst   <= next_fst;
         cmd   <= next_cmd;
         done  <= next_done;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_STROBE_IDLE: assert property (
      @(posedge clk) disable iff (reset)
      (cmd.prog || cmd.erase) |-> $past(!fl_busy))
      else $error("flash step issued while busy");

   AST_STROBE_PULSE: assert property (
      @(posedge clk) disable iff (reset)
      (cmd.prog || cmd.erase) |=> !(cmd.prog || cmd.erase || cmd.rd) ##1 !done)
      else $error("flash strobe longer than one cycle");

endmodule // fee_fop

// file: core/fee_core.sv
// fee_core: eeprom emulation on two flash pages with page recovery
// assumes an on-chip flash on clk with busy and read-valid handshakes
//
// Contract
// - two equal flash sectors, one erased spare, other active.
// - each page header sits in the first half word.
// - page state is one of empty, receiving, valid.
// - a valid page stays valid until its data is fully copied.
// - receiving plus empty: erase empty page, mark receiving page valid.
// - valid plus empty: use valid page, erase the other.
// - valid plus receiving: copy latest values, mark valid, erase old.
// - an entry is a 16-bit virtual address plus 16-bit data.
// - updates append to a fresh location, never overwrite.
// - a read returns the newest value for the address.
// - reset never aborts a running erase.
// - reset stops sequencing; a running program completes.
// - partial entries and headers are survived via header states.
// - two pages of 16 Kbytes each.
// - writes go to first empty slot; full page is signalled.
// - missing address gives lookup flag 1, else 0 with value.
`timescale 1ns/10ps
module fee_core #(
   parameter int unsigned          NVAR      = fee_pkg::NVAR,
   parameter logic [16*NVAR-1:0]   VAR_TABLE = fee_pkg::VAR_TABLE
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               init_start,
   input  wire logic               req_valid,
   input  wire fee_pkg::fee_req_t  req,
   output logic                    req_ready,
   output logic                    resp_valid,
   output fee_pkg::fee_resp_t      resp,
   output logic                    init_done,
   output fee_pkg::fee_fcmd_t      flash_cmd,
   input  wire logic               fl_busy,
   input  wire logic               fl_rvalid,
   input  wire logic [15:0]        fl_rdata
);

   localparam int unsigned IW = $clog2(NVAR + 1);
   localparam int unsigned AW = fee_pkg::AW;

   typedef enum logic [4:0] {
      S_BOOT     = 5'b00000,
      S_H0       = 5'b00001,
      S_H1       = 5'b00010,
      S_DECIDE   = 5'b00011,
      S_FMT0     = 5'b00100,
      S_FMT1     = 5'b00101,
      S_FMTH     = 5'b00110,
      S_ERO      = 5'b00111,
      S_MKV      = 5'b01000,
      S_SCAN_V   = 5'b01001,
      S_SCAN_D   = 5'b01010,
      S_IDLE     = 5'b01011,
      S_LK_V     = 5'b01100,
      S_LK_D     = 5'b01101,
      S_WR_D     = 5'b01110,
      S_WR_V     = 5'b01111,
      S_TX_RCV   = 5'b10000,
      S_TX_NEXT  = 5'b10001,
      S_TX_WD    = 5'b10010,
      S_TX_WV    = 5'b10011,
      S_TX_VALID = 5'b10100,
      S_TX_ERASE = 5'b10101
   } fee_st_t;

   fee_st_t             state, next_state;
   fee_pkg::fee_plan_t  plan, next_plan;
   fee_pkg::fee_resp_t  next_resp;
   logic                issued, next_issued;
   logic                act, next_act;
   logic                tx, next_tx;
   logic                pend, next_pend;
   logic [AW-1:0]       wptr, next_wptr;
   logic [AW-1:0]       dptr, next_dptr;
   logic [AW-1:0]       lk_ptr, next_lk_ptr;
   logic [15:0]         h0, next_h0;
   logic [15:0]         h1, next_h1;
   logic [15:0]         key, next_key;
   logic [15:0]         pvad, next_pvad;
   logic [15:0]         w_vaddr, next_w_vaddr;
   logic [15:0]         w_data, next_w_data;
   logic [IW-1:0]       tx_idx, next_tx_idx;
   logic                next_req_ready, next_resp_valid, next_init_done;

   // flash step request
   logic                op_state, fop_done;
   // plain vector so the packed multi-field assignments below stay legal
   logic [1:0]          fop_op;
   logic                fop_pg;
   logic [AW-1:0]       fop_off;
   logic [15:0]         fop_wdata, fop_rdata, tbl;
   logic                e0, e1, r0, r1, v0, v1;

   ////////////////////////////////////////////////////////////////////////
   // header decode, anything else counts as a torn header
   assign e0  = (h0 == fee_pkg::HDR_ERASED);
   assign e1  = (h1 == fee_pkg::HDR_ERASED);
   assign r0  = (h0 == fee_pkg::HDR_RECEIVE);
   assign r1  = (h1 == fee_pkg::HDR_RECEIVE);
   assign v0  = (h0 == fee_pkg::HDR_VALID);
   assign v1  = (h1 == fee_pkg::HDR_VALID);
   assign tbl = VAR_TABLE[16*int'(tx_idx) +: 16];

   ////////////////////////////////////////////////////////////////////////
   // which flash step each state needs; data at slot, vaddr at slot+1
   always_comb begin
      op_state  = 1'b1;
      fop_op    = fee_pkg::FEE_RD;
      fop_pg    = act;
      fop_off   = fee_pkg::HDR_OFF;
      fop_wdata = fee_pkg::HDR_VALID;
      case (state)
         S_H0:       fop_pg = 1'b0;
         S_H1:       fop_pg = 1'b1;
         S_FMT0:     {fop_op, fop_pg} = {fee_pkg::FEE_ERASE, 1'b0};
         S_FMT1:     {fop_op, fop_pg} = {fee_pkg::FEE_ERASE, 1'b1};
         S_FMTH:     {fop_op, fop_pg} = {fee_pkg::FEE_PROG, 1'b0};
         S_ERO:      {fop_op, fop_pg} = {fee_pkg::FEE_ERASE, ~act};
         S_MKV:      fop_op = fee_pkg::FEE_PROG;
         S_SCAN_V: begin
            fop_off  = wptr + 14'h0001;
            // a read started at page end would be taken as the next step's done
            op_state = (wptr != fee_pkg::PAGE_END);
         end
         S_SCAN_D:   fop_off = wptr;
         S_LK_V:     fop_off = lk_ptr + 14'h0001;
         S_LK_D:     fop_off = lk_ptr;
         S_WR_D: begin
            {fop_op, fop_off, fop_wdata} = {fee_pkg::FEE_PROG, wptr, w_data};
         end
         S_WR_V: begin
            fop_op    = fee_pkg::FEE_PROG;
            fop_off   = wptr + 14'h0001;
            fop_wdata = w_vaddr;
         end
         S_TX_RCV: begin
            {fop_op, fop_pg} = {fee_pkg::FEE_PROG, ~act};
            fop_wdata = fee_pkg::HDR_RECEIVE;
         end
         S_TX_WD: begin
            {fop_op, fop_pg, fop_off} = {fee_pkg::FEE_PROG, ~act, dptr};
            fop_wdata = w_data;
         end
         S_TX_WV: begin
            {fop_op, fop_pg, fop_off} = {fee_pkg::FEE_PROG, ~act, dptr + 14'h0001};
            fop_wdata = w_vaddr;
         end
         S_TX_VALID: {fop_op, fop_pg} = {fee_pkg::FEE_PROG, ~act};
         S_TX_ERASE: fop_op = fee_pkg::FEE_ERASE;
         default:    op_state = 1'b0;
      endcase
   end

   fee_fop u_fop (
      .clk       (clk),
      .reset     (reset),
      .start     (op_state && !issued),
      .op        (fee_pkg::fee_op_t'(fop_op)),
      .addr      ({fop_pg, fop_off[AW-2:0]}),
      .wdata     (fop_wdata),
      .done      (fop_done),
      .rdata     (fop_rdata),
      .cmd       (flash_cmd),
      .fl_busy   (fl_busy),
      .fl_rvalid (fl_rvalid),
      .fl_rdata  (fl_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state      = state;
      next_plan       = plan;
      next_issued     = issued ? !fop_done : (op_state && !issued);
      next_act        = act;
      next_tx         = tx;
      next_pend       = pend;
      next_wptr       = wptr;
      next_dptr       = dptr;
      next_lk_ptr     = lk_ptr;
      next_h0         = h0;
      next_h1         = h1;
      next_key        = key;
      next_pvad       = pvad;
      next_w_vaddr    = w_vaddr;
      next_w_data     = w_data;
      next_tx_idx     = tx_idx;
      next_resp       = resp;
      next_resp_valid = 1'b0;
      next_init_done  = init_done;
      case (state)
         S_BOOT: if (init_start) next_state = S_H0;
         S_H0: if (fop_done) begin
            next_h0    = fop_rdata;
            next_state = S_H1;
         end
         S_H1: if (fop_done) begin
            next_h1    = fop_rdata;
            next_state = S_DECIDE;
         end
         S_DECIDE: begin
            next_wptr   = fee_pkg::FIRST_ENTRY;
            next_dptr   = fee_pkg::FIRST_ENTRY;
            next_tx_idx = '0;
            next_pend   = 1'b0;
            next_act    = (v0 || v1) ? v1 : r1;
            if ((h0 == h1) || !(e0 || r0 || v0) || !(e1 || r1 || v1)) begin
               next_state = S_FMT0;
            end else if ((v0 || v1) && (r0 || r1)) begin
               next_plan  = fee_pkg::P_TX;
               next_state = S_SCAN_V;
            end else begin
               next_plan  = (v0 || v1) ? fee_pkg::P_USE : fee_pkg::P_MKV;
               next_state = S_ERO;
            end
         end
         S_FMT0: if (fop_done) next_state = S_FMT1;
         S_FMT1: if (fop_done) next_state = S_FMTH;
         S_FMTH: if (fop_done) begin
            next_act       = 1'b0;
            next_init_done = 1'b1;
            next_state     = S_IDLE;
         end
         S_ERO: if (fop_done) begin
            case (plan)
               fee_pkg::P_TX:  next_state = S_TX_RCV;
               fee_pkg::P_MKV: next_state = S_MKV;
               default:        next_state = S_SCAN_V;
            endcase
         end
         S_MKV: if (fop_done) next_state = S_SCAN_V;
         // find first free slot; a slot with data but no vaddr is skipped
         S_SCAN_V, S_SCAN_D: begin
            if (state == S_SCAN_V && wptr == fee_pkg::PAGE_END) begin
               next_state = (plan == fee_pkg::P_TX) ? S_ERO : S_IDLE;
               next_init_done = (plan != fee_pkg::P_TX);
            end else if (fop_done) begin
               if (fop_rdata != fee_pkg::HDR_ERASED) begin
                  next_wptr  = wptr + fee_pkg::ENTRY_HW;
                  next_state = S_SCAN_V;
               end else if (state == S_SCAN_V) begin
                  next_state = S_SCAN_D;
               end else begin
                  next_state = (plan == fee_pkg::P_TX) ? S_ERO : S_IDLE;
                  next_init_done = (plan != fee_pkg::P_TX);
               end
            end
         end
         S_IDLE: begin
            if (init_start) begin
               next_init_done = 1'b0;
               next_state     = S_H0;
            end else if (req_valid && req_ready) begin
               next_key     = req.vaddr;
               next_pvad    = req.vaddr;
               next_w_vaddr = req.vaddr;
               next_w_data  = req.wdata;
               next_tx      = 1'b0;
               next_lk_ptr  = wptr - fee_pkg::ENTRY_HW;
               if (req.write && wptr == fee_pkg::PAGE_END) begin
                  next_pend   = 1'b1;
                  next_dptr   = fee_pkg::FIRST_ENTRY;
                  next_tx_idx = '0;
                  next_state  = S_TX_RCV;
               end else if (req.write) begin
                  next_state = S_WR_D;
               end else if (wptr == fee_pkg::FIRST_ENTRY) begin
                  next_resp       = '{16'h0000, 1'b1, 1'b0};
                  next_resp_valid = 1'b1;
               end else begin
                  next_state = S_LK_V;
               end
            end
         end
         // newest entry first, so the first match is the latest value
         S_LK_V: if (fop_done) begin
            if (fop_rdata == key) begin
               next_state = S_LK_D;
            end else if (lk_ptr == fee_pkg::FIRST_ENTRY) begin
               if (tx) begin
                  next_tx_idx = tx_idx + IW'(1);
                  next_state  = S_TX_NEXT;
               end else begin
                  next_resp       = '{16'h0000, 1'b1, 1'b0};
                  next_resp_valid = 1'b1;
                  next_state      = S_IDLE;
               end
            end else begin
               next_lk_ptr = lk_ptr - fee_pkg::ENTRY_HW;
            end
         end
         S_LK_D: if (fop_done) begin
            if (tx) begin
               next_w_vaddr = key;
               next_w_data  = fop_rdata;
               next_state   = S_TX_WD;
            end else begin
               next_resp       = '{fop_rdata, 1'b0, 1'b0};
               next_resp_valid = 1'b1;
               next_state      = S_IDLE;
            end
         end
         S_WR_D: if (fop_done) next_state = S_WR_V;
         S_WR_V: if (fop_done) begin
            next_wptr       = wptr + fee_pkg::ENTRY_HW;
            next_resp       = '{16'h0000, 1'b0, 1'b0};
            next_resp_valid = 1'b1;
            next_state      = S_IDLE;
         end
         S_TX_RCV: if (fop_done) begin
            next_tx    = 1'b0;
            next_state = pend ? S_TX_WD : S_TX_NEXT;
         end
         S_TX_WD: if (fop_done) next_state = S_TX_WV;
         S_TX_WV: if (fop_done) begin
            next_dptr   = dptr + fee_pkg::ENTRY_HW;
            next_tx_idx = tx ? tx_idx + IW'(1) : tx_idx;
            next_state  = S_TX_NEXT;
         end
         S_TX_NEXT: begin
            if (tx_idx == IW'(NVAR)) begin
               next_state = S_TX_VALID;
            end else if ((pend && tbl == pvad) || wptr == fee_pkg::FIRST_ENTRY) begin
               next_tx_idx = tx_idx + IW'(1);
            end else begin
               next_key    = tbl;
               next_lk_ptr = wptr - fee_pkg::ENTRY_HW;
               next_tx     = 1'b1;
               next_state  = S_LK_V;
            end
         end
         // the old page keeps its valid header until the copy is marked
         S_TX_VALID: if (fop_done) next_state = S_TX_ERASE;
         S_TX_ERASE: if (fop_done) begin
            next_act        = ~act;
            next_wptr       = dptr;
            next_pend       = 1'b0;
            next_init_done  = 1'b1;
            next_resp       = '{16'h0000, 1'b0, 1'b1};
            next_resp_valid = pend;
            next_state      = S_IDLE;
         end
         default: next_state = S_BOOT;
      endcase
      next_req_ready = (next_state == S_IDLE) && next_init_done;
   end

   ////////////////////////////////////////////////////////////////////////
   // reset drops the sequence; the flash finishes on its own
   always_ff @(posedge clk) begin
      if (reset) begin
         state      <= S_BOOT;
         plan       <= fee_pkg::P_USE;
         issued     <= 1'b0;
         act        <= 1'b0;
         tx         <= 1'b0;
         pend       <= 1'b0;
         wptr       <= fee_pkg::FIRST_ENTRY;
         dptr       <= fee_pkg::FIRST_ENTRY;
         lk_ptr     <= fee_pkg::FIRST_ENTRY;
         h0         <= fee_pkg::HDR_ERASED;
         h1         <= fee_pkg::HDR_ERASED;
         key        <= 16'h0000;
         pvad       <= 16'h0000;
         w_vaddr    <= 16'h0000;
         w_data     <= 16'h0000;
         tx_idx     <= '0;
         resp       <= '0;
         resp_valid <= 1'b0;
         req_ready  <= 1'b0;
         init_done  <= 1'b0;
      end else begin
         state      <= next_state;
         plan       <= next_plan;
         issued     <= next_issued;
         act        <= next_act;
         tx         <= next_tx;
         pend       <= next_pend;
         wptr       <= next_wptr;
         dptr       <= next_dptr;
         lk_ptr     <= next_lk_ptr;
         h0         <= next_h0;
         h1         <= next_h1;
         key        <= next_key;
         pvad       <= next_pvad;
         w_vaddr    <= next_w_vaddr;
         w_data     <= next_w_data;
         tx_idx     <= next_tx_idx;
         resp       <= next_resp;
         resp_valid <= next_resp_valid;
         req_ready  <= next_req_ready;
         init_done  <= next_init_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_FORMAT_EQUAL: assert property (
      @(posedge clk) disable iff (reset)
      (state == S_DECIDE && h0 == h1) |=> state == S_FMT0 ##[1:1000] state != S_FMT0)
      else $error("equal headers not formatted");

   AST_HDR_CODE: assert property (
      @(posedge clk) disable iff (reset)
      (flash_cmd.prog && flash_cmd.addr[AW-2:0] == '0) |->
         (flash_cmd.data == fee_pkg::HDR_VALID || flash_cmd.data == fee_pkg::HDR_RECEIVE))
      else $error("header programmed with unknown code");

   AST_APPEND_SLOT: assert property (
      @(posedge clk) disable iff (reset)
      (state == S_WR_D && fop_done) |=> state == S_WR_V && wptr < fee_pkg::PAGE_END)
      else $error("entry write past page end");

   AST_FULL_SWAP: assert property (
      @(posedge clk) disable iff (reset)
      (state == S_IDLE && req_valid && req_ready && req.write && wptr == fee_pkg::PAGE_END)
         |=> state == S_TX_RCV && pend)
      else $error("full page did not start a swap");

   AST_NOT_FOUND: assert property (
      @(posedge clk) disable iff (reset)
      (state == S_LK_V && fop_done && !tx && fop_rdata != key
         && lk_ptr == fee_pkg::FIRST_ENTRY) |=> resp_valid && resp.lookup_result_flag)
      else $error("missing variable not flagged");

   AST_MARK_THEN_ERASE: assert property (
      @(posedge clk) disable iff (reset)
      (state == S_TX_VALID && fop_done) |=> state == S_TX_ERASE ##1 !flash_cmd.prog)
      else $error("old page erased before copy marked valid");

endmodule // fee_core

// file: testbench/fee_flash_model.sv
// fee_flash_model: behavioural two-sector half-word flash
// assumes one strobe at a time from fee_core, no reset of its own
`timescale 1ns/10ps
module fee_flash_model (
   input  wire logic               clk,
   input  wire fee_pkg::fee_fcmd_t cmd,
   output logic                    fl_busy,
   output logic                    fl_rvalid,
   output logic [15:0]             fl_rdata
);
   logic [15:0] mem [16384];
   logic [13:0] a;
   logic [15:0] d;
   logic        e;
   int          n = 0;
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
      fl_busy = 1'b0;
      fl_rvalid = 1'b0;
      fl_rdata = 16'h0000;
   end
   // no reset input: a running erase or program always finishes
   always @(posedge clk) begin
      fl_rvalid <= cmd.rd;
      // idle bus toggles so a stale value never reads as data
      fl_rdata <= cmd.rd ? mem[cmd.addr] : ~fl_rdata;
      if (cmd.prog || cmd.erase) begin
         fl_busy <= 1'b1;
         n <= cmd.erase ? 30 : $urandom_range(1, 6);
         {e, a, d} <= {cmd.erase, cmd.addr, cmd.data};
      end else if (n > 1) begin
         n <= n - 1;
      end else if (fl_busy) begin
         fl_busy <= 1'b0;
         if (e) begin
            for (int i = 0; i < 8192; i++) mem[{a[13], i[12:0]}] <= 16'hffff;
         end else begin
            mem[a] <= mem[a] & d; // programming only clears bits
         end
      end
   end
endmodule // fee_flash_model

// file: testbench/fee_core_tb_top.sv
// fee_core_tb_top: self-checking bench for fee_core
// assumes fee_flash_model on the flash side, one clock
`timescale 1ns/10ps
module fee_core_tb_top;
   logic               clk = 0, reset = 1, init_start = 0, req_valid = 0;
   fee_pkg::fee_req_t  req = '0;
   logic               req_ready, resp_valid, init_done, fl_busy, fl_rvalid;
   fee_pkg::fee_resp_t resp;
   fee_pkg::fee_fcmd_t flash_cmd;
   logic [15:0]        fl_rdata, v [3], va [3];
   int                 fail_count = 0, checked = 0;
   fee_pkg::fee_resp_t expq [$];
   always #4 clk = ~clk;
   fee_core fee_core_i (.clk(clk), .reset(reset), .init_start(init_start),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp(resp), .init_done(init_done), .flash_cmd(flash_cmd), .fl_busy(fl_busy),
      .fl_rvalid(fl_rvalid), .fl_rdata(fl_rdata));
   fee_flash_model fee_flash_model_i (.clk(clk), .cmd(flash_cmd), .fl_busy(fl_busy),
      .fl_rvalid(fl_rvalid), .fl_rdata(fl_rdata));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [17:0] x, logic [17:0] s);
      checked++;
      if (x !== s) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic summarize();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bound(logic ok, string n);
      if (!ok) begin
         fail_count++;
         $display("unexpected %s expected done seen timeout", n);
         summarize();
      end
   endtask
   always @(posedge clk) begin
      if (resp_valid === 1'b1) begin
         if (expq.size() == 0) chk("resp count", 18'h0, 18'h1);
         else chk("resp", expq.pop_front(), resp);
      end
   end
   // bounded recovery after a three-cycle reset
   task automatic recover();
      int k;
      @(posedge clk) reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk) init_start <= 1'b1;
      @(posedge clk) init_start <= 1'b0;
      for (k = 0; k < 50000 && init_done !== 1'b1; k++) @(posedge clk);
      bound(k < 50000, "init_done");
   endtask
   task automatic access(logic w, int i, logic [15:0] wd, fee_pkg::fee_resp_t x);
      logic r;
      int   k;
      @(posedge clk) req_valid <= 1'b1;
      req <= '{write: w, vaddr: va[i], wdata: wd};
      expq.push_back(x);
      for (k = 0; k < 5000; k++) begin
         #1 r = req_ready;
         @(posedge clk);
         if (r === 1'b1) break;
      end
      req_valid <= 1'b0;
      for (; k < 5000 && expq.size() != 0; k++) @(posedge clk);
      bound(k < 5000, "resp_valid");
   endtask
   task automatic read_all();
      for (int i = 0; i < 3; i++) access(0, i, 16'h0000, '{v[i], 1'b0, 1'b0});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h2ee3b97b));
      {va[0], va[1], va[2]} = {16'h5555, 16'h6666, 16'h7777};
      recover();
      chk("header first_page", fee_pkg::HDR_VALID, fee_flash_model_i.mem[0]);
      for (int i = 0; i < 3; i++) access(0, i, 16'h0000, '{16'h0000, 1'b1, 1'b0});
      $display("test blank done");
      for (int i = 0; i < 4; i++) begin
         v[i % 3] = $urandom;
         access(1, i % 3, v[i % 3], '0);
         if (i == 0) access(0, 1, 16'h0000, '{16'h0000, 1'b1, 1'b0});
      end
      chk("entry data", v[0], fee_flash_model_i.mem[8]);
      chk("entry vaddr", va[0], fee_flash_model_i.mem[9]);
      chk("first entry vaddr", va[0], fee_flash_model_i.mem[3]);
      read_all();
      $display("test update done");
      recover();
      read_all();
      fee_flash_model_i.mem[8192] = fee_pkg::HDR_RECEIVE;
      recover();
      chk("valid second_page", fee_pkg::HDR_VALID, fee_flash_model_i.mem[8192]);
      chk("erased first_page", fee_pkg::HDR_ERASED, fee_flash_model_i.mem[0]);
      read_all();
      fee_flash_model_i.mem[8192] = fee_pkg::HDR_RECEIVE;
      recover();
      chk("marked second_page", fee_pkg::HDR_VALID, fee_flash_model_i.mem[8192]);
      read_all();
      $display("test recovery done");
      // fill the active page to its end so the next write must swap
      for (int s = 8; s < 8192; s += 2) begin
         fee_flash_model_i.mem[8192 + s] = v[(s / 2) % 3];
         fee_flash_model_i.mem[8193 + s] = va[(s / 2) % 3];
      end
      recover();
      v[0] = ~v[0];
      access(1, 0, v[0], '{16'h0000, 1'b0, 1'b1});
      chk("swap header first_page", fee_pkg::HDR_VALID, fee_flash_model_i.mem[0]);
      chk("swap erased second_page", fee_pkg::HDR_ERASED, fee_flash_model_i.mem[8192]);
      chk("swap entry data", v[0], fee_flash_model_i.mem[2]);
      read_all();
      $display("test swap done");
      summarize();
   end
endmodule // fee_core_tb_top
